/* cirt_host.sv */
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module cirt_fifo2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic         wp_q, rp_q;
  logic [1:0]   cnt_q;
  logic         push, pop;

  assign in_ready  = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

module cirt_host
  import cirt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  cirt_link_if.host        link
);
  localparam logic [6:0] QTR_LAST = 7'(CIRT_QTR_CYC - 1);

  logic        scl_m, scl_s, sda_m, sda_s;
  logic        pready_q, pslverr_q, zero_q;
  logic [31:0] prdata_q;
  cirt_mst_e   st_q;
  cirt_byte_e  step_q;
  logic [1:0]  ph_q;
  logic [6:0]  tc_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q, idx_q, left_q;
  logic        rxb_q, rd_q, nack_q, nflag_q, scl_oe_q, sda_oe_q;

  logic        acc, go, tick, ok, adv, need_tx, busy;
  logic        tx_push, tx_rdy, tx_v, rx_push, rx_rdy, rx_v, rx_pop;
  logic [7:0]  tx_d, rx_d;

  assign acc     = psel & penable & !pready_q;
  assign busy    = st_q != M_IDLE;
  assign go      = acc & pwrite & (paddr == CIRT_OFS_CMD) & !busy & pwdata[CIRT_CMD_GO];
  assign tx_push = acc & pwrite & (paddr == CIRT_OFS_TX);
  assign rx_pop  = acc & !pwrite & (paddr == CIRT_OFS_RX);
  assign tick    = tc_q == QTR_LAST;
  assign adv     = tick & ok;
  assign rx_push = tick & (st_q == M_BIT) & (ph_q == 2'h3) & rxb_q & (bit_q == 4'h7);

  cirt_fifo2 #(.W(8)) u_txf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (tx_push),
    .in_ready  (tx_rdy),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_v),
    .out_ready (adv & need_tx),
    .out_data  (tx_d)
  );

  cirt_fifo2 #(.W(8)) u_rxf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (rx_push),
    .in_ready  (rx_rdy),
    .in_data   (sh_q),
    .out_valid (rx_v),
    .out_ready (rx_pop),
    .out_data  (rx_d)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      if (acc) begin
        prdata_q <= 32'h0000_0000;
        unique case (paddr)
          CIRT_OFS_CMD: begin
            pready_q  <= 1'b1;
            pslverr_q <= pwrite & busy;
            prdata_q  <= {15'h0000, rd_q, left_q, idx_q};
          end
          CIRT_OFS_TX: begin
            // a full buffer stalls the bus write
            pready_q <= !pwrite | tx_rdy;
          end
          CIRT_OFS_RX: begin
            pready_q <= 1'b1;
            prdata_q <= {23'h000000, rx_v, rx_d};
          end
          CIRT_OFS_STAT: begin
            pready_q <= 1'b1;
            prdata_q <= {28'h0000000, rx_v, !tx_rdy, nflag_q, busy};
          end
          default: begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m  <= 1'b1;
      scl_s  <= 1'b1;
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
      zero_q <= 1'b0;
      tc_q   <= 7'h00;
    end else begin
      scl_m  <= link.scl;
      scl_s  <= scl_m;
      sda_m  <= link.sda;
      sda_s  <= sda_m;
      zero_q <= 1'b0;
      if (!busy || adv) begin
        tc_q <= 7'h00;
      end else if (!tick) begin
        tc_q <= tc_q + 7'h01;
      end
    end
  end

  always_comb begin
    ok      = 1'b1;
    need_tx = 1'b0;
    if (st_q != M_START && ph_q == 2'h2) begin
      ok = scl_s;
    end
    if (st_q == M_BIT && ph_q == 2'h3 && rxb_q && bit_q == 4'h7) begin
      ok = rx_rdy;
    end
    if (st_q == M_BIT && ph_q == 2'h3 && bit_q == 4'h8 && !rxb_q && !nack_q &&
        ((step_q == K_IX && !rd_q) || step_q == K_WD) && left_q != 8'h00) begin
      need_tx = 1'b1;
      ok      = tx_v;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= M_IDLE;
      step_q   <= K_AW;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      idx_q    <= 8'h00;
      left_q   <= 8'h00;
      rxb_q    <= 1'b0;
      rd_q     <= 1'b0;
      nack_q   <= 1'b0;
      nflag_q  <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        M_IDLE: if (go) begin
          st_q    <= M_START;
          ph_q    <= 2'h0;
          nflag_q <= 1'b0;
          rd_q    <= pwdata[CIRT_CMD_RD];
          idx_q   <= pwdata[7:0];
          left_q  <= pwdata[CIRT_CMD_LEN +: 8];
          if (pwdata[CIRT_CMD_RD] && pwdata[CIRT_CMD_LEN +: 8] == 8'h00) begin
            left_q <= 8'h01;
          end
        end
        M_START: if (adv) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h1) begin
            sda_oe_q <= 1'b1;
          end
          if (ph_q == 2'h2) begin
            scl_oe_q <= 1'b1;
            st_q     <= M_BIT;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            rxb_q    <= 1'b0;
            step_q   <= K_AW;
            sh_q     <= {CIRT_TGT_ADDR, 1'b0};
          end
        end
        M_BIT: if (adv) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_q <= (bit_q == 4'h8) ? (rxb_q & left_q != 8'h00) : (!rxb_q & !sh_q[7]);
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (bit_q == 4'h8) begin
                nack_q <= sda_s;
              end else begin
                sh_q <= {sh_q[6:0], rxb_q & sda_s};
              end
            end
            2'h3: begin
              scl_oe_q <= 1'b1;
              bit_q    <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                if (!rxb_q && nack_q) begin
                  st_q    <= M_STOP;
                  nflag_q <= 1'b1;
                end else begin
                  unique case (step_q)
                    K_AW: begin
                      step_q <= K_IX;
                      sh_q   <= idx_q;
                    end
                    K_IX, K_WD: begin
                      if (rd_q && step_q == K_IX) begin
                        st_q   <= M_RSTART;
                        step_q <= K_AR;
                        sh_q   <= {CIRT_TGT_ADDR, 1'b1};
                      end else if (left_q == 8'h00) begin
                        st_q <= M_STOP;
                      end else begin
                        step_q <= K_WD;
                        sh_q   <= tx_d;
                        left_q <= left_q - 8'h01;
                      end
                    end
                    K_AR: begin
                      step_q <= K_RD;
                      rxb_q  <= 1'b1;
                      left_q <= left_q - 8'h01;
                    end
                    K_RD: begin
                      if (left_q == 8'h00) begin
                        st_q <= M_STOP;
                      end else begin
                        left_q <= left_q - 8'h01;
                      end
                    end
                    default: st_q <= M_STOP;
                  endcase
                end
              end
            end
          endcase
        end
        M_RSTART: if (adv) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            2'h3: begin
              scl_oe_q <= 1'b1;
              st_q     <= M_BIT;
              bit_q    <= 4'h0;
            end
          endcase
        end
        M_STOP: if (adv) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            2'h3: st_q     <= M_IDLE;
          endcase
        end
      endcase
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign link.m_scl_o  = zero_q;
  assign link.m_sda_o  = zero_q;
  assign link.m_scl_oe = scl_oe_q;
  assign link.m_sda_oe = sda_oe_q;

endmodule
`default_nettype wire

/* cirt_pkg.sv */
package cirt_pkg;

  localparam logic [6:0] CIRT_TGT_ADDR = 7'h6B;
  localparam logic [7:0] CIRT_IDX_LAST = 8'h05;

  localparam logic [7:0] CIRT_REG_RST  [6] = '{8'h0E, 8'hE7, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CIRT_REG_MASK [6] = '{8'hFF, 8'hFF, 8'hC0, 8'h1F, 8'hF8, 8'h7F};

  localparam int CIRT_ICHG_STEP_MA = 64;
  localparam int CIRT_VCHG_STEP_MV = 8;
  localparam int CIRT_ICHG_LSB     = 6;
  localparam int CIRT_VCHG_LSB     = 3;
  localparam logic [11:0] CIRT_VDEF_1S = 12'(4200 / CIRT_VCHG_STEP_MV);
  localparam logic [11:0] CIRT_VDEF_2S = 12'(8400 / CIRT_VCHG_STEP_MV);
  localparam logic [11:0] CIRT_VDEF_3S = 12'(12600 / CIRT_VCHG_STEP_MV);
  localparam logic [11:0] CIRT_VDEF_4S = 12'(16800 / CIRT_VCHG_STEP_MV);
  localparam logic [1:0]  CIRT_STRAP_LOAD = 2'h2;

  localparam int CIRT_CLK_NS  = 20;
  localparam int CIRT_QTR_NS  = 2500;
  localparam int CIRT_QTR_CYC = (CIRT_QTR_NS + CIRT_CLK_NS - 1) / CIRT_CLK_NS;

  localparam logic [7:0] CIRT_OFS_CMD  = 8'h00;
  localparam logic [7:0] CIRT_OFS_TX   = 8'h04;
  localparam logic [7:0] CIRT_OFS_RX   = 8'h08;
  localparam logic [7:0] CIRT_OFS_STAT = 8'h0C;
  localparam int CIRT_CMD_GO  = 31;
  localparam int CIRT_CMD_RD  = 16;
  localparam int CIRT_CMD_LEN = 8;

  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_INDEX, T_WDATA, T_RDATA} cirt_tst_e;
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_RSTART, M_STOP} cirt_mst_e;
  typedef enum logic [2:0] {K_AW, K_IX, K_WD, K_AR, K_RD} cirt_byte_e;

endpackage

/* cirt_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cirt_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_scl_o;
  logic t_scl_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl;
  logic sda;

  // wired-and of both open-drain ends, pulled up when released
  assign scl = !((m_scl_oe & !m_scl_o) | (t_scl_oe & !t_scl_o));
  assign sda = !((m_sda_oe & !m_sda_o) | (t_sda_oe & !t_sda_o));

  modport target (
    input  scl,
    input  sda,
    output t_scl_o,
    output t_scl_oe,
    output t_sda_o,
    output t_sda_oe
  );
  modport host (
    input  scl,
    input  sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );
endinterface
`default_nettype wire

/* cirt_target.sv */
`timescale 1ns/10ps
`default_nettype none
module cirt_target
  import cirt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  cirt_link_if.target      link,
  input  wire logic [1:0]  cell_count,
  output logic      [15:0] charge_option,
  output logic      [6:0]  charge_current_code,
  output logic      [11:0] charge_voltage_code
);

  logic       scl_m, scl_s, scl_p;
  logic       sda_m, sda_s, sda_p;
  logic [1:0] cell_m, cell_s;
  logic [1:0] init_q;
  logic       zero_q;
  logic       sda_oe_q;
  logic       ack_q;
  logic       mack_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] idx_q;
  logic [7:0] regs_q [6];
  cirt_tst_e  tst_q;

  logic       rise, fall, start_c, stop_c;
  logic       byte_end, wr_en;
  logic [7:0] rdata;
  logic [11:0] vdef;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign rise     = scl_s & !scl_p;
  assign fall     = !scl_s & scl_p;
  assign start_c  = scl_s & scl_p & sda_p & !sda_s;
  assign stop_c   = scl_s & scl_p & !sda_p & sda_s;
  assign byte_end = fall & !ack_q & (cnt_q == 4'h8) & !start_c & !stop_c;
  assign wr_en    = byte_end & (tst_q == T_WDATA) & (idx_q <= CIRT_IDX_LAST);
  assign rdata    = (idx_q <= CIRT_IDX_LAST) ? regs_q[idx_q[2:0]] : 8'h00;

  // strap is synchronised, then caught once after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_m <= 2'h0;
      cell_s <= 2'h0;
      init_q <= 2'h0;
      zero_q <= 1'b0;
    end else begin
      cell_m <= cell_count;
      cell_s <= cell_m;
      zero_q <= 1'b0;
      if (init_q != 2'h3) begin
        init_q <= init_q + 2'h1;
      end
    end
  end

  always_comb begin
    unique case (cell_s)
      2'h0: vdef = CIRT_VDEF_1S;
      2'h1: vdef = CIRT_VDEF_2S;
      2'h2: vdef = CIRT_VDEF_3S;
      2'h3: vdef = CIRT_VDEF_4S;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) begin
        regs_q[i] <= CIRT_REG_RST[i];
      end
    end else begin
      if (init_q == CIRT_STRAP_LOAD) begin
        regs_q[4] <= {vdef[4:0], 3'h0};
        regs_q[5] <= {1'b0, vdef[11:5]};
      end
      if (wr_en) begin
        regs_q[idx_q[2:0]] <= sh_q & CIRT_REG_MASK[idx_q[2:0]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_q    <= T_IDLE;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      mack_q   <= 1'b0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      idx_q    <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      tst_q    <= T_ADDR;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      tst_q    <= T_IDLE;
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (tst_q != T_IDLE) begin
      if (rise) begin
        if (ack_q) begin
          mack_q <= !sda_s;
        end else if (cnt_q != 4'h8) begin
          sh_q  <= {sh_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (byte_end) begin
        ack_q <= 1'b1;
        unique case (tst_q)
          T_ADDR: begin
            if (sh_q[7:1] == CIRT_TGT_ADDR) begin
              sda_oe_q <= 1'b1;
            end else begin
              tst_q <= T_IDLE;
            end
          end
          T_INDEX: begin
            if (sh_q <= CIRT_IDX_LAST) begin
              sda_oe_q <= 1'b1;
              idx_q    <= sh_q;
            end else begin
              tst_q <= T_IDLE;
            end
          end
          T_WDATA: begin
            if (idx_q <= CIRT_IDX_LAST) begin
              sda_oe_q <= 1'b1;
              idx_q    <= idx_q + 8'h01;
            end else begin
              tst_q <= T_IDLE;
            end
          end
          T_RDATA: sda_oe_q <= 1'b0;
          default: sda_oe_q <= 1'b0;
        endcase
      end else if (fall && ack_q) begin
        ack_q <= 1'b0;
        cnt_q <= 4'h0;
        unique case (tst_q)
          T_ADDR: begin
            if (sh_q[0]) begin
              tst_q    <= T_RDATA;
              sda_oe_q <= !rdata[7];
              tx_q     <= {rdata[6:0], 1'b0};
              idx_q    <= idx_q + 8'h01;
            end else begin
              tst_q    <= T_INDEX;
              sda_oe_q <= 1'b0;
            end
          end
          T_INDEX: begin
            tst_q    <= T_WDATA;
            sda_oe_q <= 1'b0;
          end
          T_RDATA: begin
            if (mack_q) begin
              sda_oe_q <= !rdata[7];
              tx_q     <= {rdata[6:0], 1'b0};
              idx_q    <= idx_q + 8'h01;
            end else begin
              tst_q    <= T_IDLE;
              sda_oe_q <= 1'b0;
            end
          end
          default: sda_oe_q <= 1'b0;
        endcase
      end else if (fall && tst_q == T_RDATA) begin
        sda_oe_q <= !tx_q[7];
        tx_q     <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign link.t_scl_o  = zero_q;
  assign link.t_scl_oe = zero_q;
  assign link.t_sda_o  = zero_q;
  assign link.t_sda_oe = sda_oe_q;

  assign charge_option       = {regs_q[1], regs_q[0]};
  assign charge_current_code = {regs_q[3][4:0], regs_q[2][7:6]};
  assign charge_voltage_code = {regs_q[5][6:0], regs_q[4][7:3]};

endmodule
`default_nettype wire

/* cirt_link_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module cirt_link_chk
  import cirt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic t_scl_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe
);
  logic       scl_q;
  logic       sda_q;
  logic       rd_q;
  logic [3:0] bit_q;
  logic [7:0] byte_q;
  logic [7:0] sh_q;
  logic       rise;
  logic       fall;
  logic       cond;
  assign rise = scl && !scl_q;
  assign fall = !scl && scl_q;
  // start or stop: data moves while clock stays high
  assign cond = scl && scl_q && (sda != sda_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q  <= 4'h0;
      byte_q <= 8'h00;
    end else if (cond) begin
      bit_q  <= 4'h0;
      byte_q <= 8'h00;
    end else if (rise && bit_q == 4'h8) begin
      bit_q  <= 4'h0;
      byte_q <= byte_q + 8'h01;
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (rise && bit_q < 4'h8) begin
      sh_q <= {sh_q[6:0], sda};
      if (bit_q == 4'h7 && byte_q == 8'h00) begin
        rd_q <= sda;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_frame_whole_bytes: assert property (cond |-> bit_q <= 4'h1)
    else $error("frame ended inside a byte");
  chk_addr_ack: assert property (
    rise && bit_q == 4'h8 && byte_q == 8'h00 && sh_q[7:1] == CIRT_TGT_ADDR |-> !sda)
    else $error("own address not acknowledged");
  chk_index_ack: assert property (
    rise && bit_q == 4'h8 && byte_q == 8'h01 && !rd_q |-> sda == (sh_q > CIRT_IDX_LAST))
    else $error("index answer wrong");
  chk_host_rd_release: assert property (
    fall && rd_q && byte_q != 8'h00 && bit_q != 4'h0 |-> !m_sda_oe)
    else $error("host drove data during read byte");
  chk_tgt_ack_release: assert property (
    fall && rd_q && byte_q >= 8'h02 && bit_q == 4'h0 |-> !t_sda_oe)
    else $error("target drove host ack slot");
  chk_host_ack_release: assert property (
    fall && bit_q == 4'h0 && byte_q != 8'h00 && (!rd_q || byte_q == 8'h01) |-> !m_sda_oe)
    else $error("host drove target ack slot");
  chk_tgt_wr_release: assert property (
    fall && bit_q != 4'h0 && (!rd_q || byte_q == 8'h00) |-> !t_sda_oe)
    else $error("target drove host data bit");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_open_drain: assert property (!t_scl_oe && !t_sda_o && !m_sda_o)
    else $error("line driven high or clock held by target");
  // target data moves only while clock low
  chk_tgt_sda_stable: assert property (scl && scl_q |-> $stable(t_sda_oe))
    else $error("target changed data while clock high");
  cover property (cond && !sda);
  cover property (rise && bit_q == 4'h8 && rd_q && byte_q >= 8'h02 && !sda);
  cover property (rise && bit_q == 4'h8 && byte_q == 8'h01 && sda);
endmodule
`default_nettype wire

/* charger_i2c_register_target_test.sv */
`timescale 1ns/10ps
`default_nettype none
module charger_i2c_register_target_test;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [1:0]  cell_count = 2'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] charge_option;
  logic [6:0]  charge_current_code;
  logic [11:0] charge_voltage_code;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  always #10 pclk = ~pclk;
  cirt_link_if cirt_link_if_i ();
  cirt_target cirt_target_i (.pclk(pclk), .presetn(presetn), .link(cirt_link_if_i),
    .cell_count(cell_count), .charge_option(charge_option),
    .charge_current_code(charge_current_code), .charge_voltage_code(charge_voltage_code));
  cirt_host cirt_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(cirt_link_if_i));
  cirt_link_chk cirt_link_chk_i (.pclk(pclk), .presetn(presetn), .scl(cirt_link_if_i.scl),
    .sda(cirt_link_if_i.sda), .m_sda_o(cirt_link_if_i.m_sda_o),
    .m_sda_oe(cirt_link_if_i.m_sda_oe), .t_scl_oe(cirt_link_if_i.t_scl_oe),
    .t_sda_o(cirt_link_if_i.t_sda_o), .t_sda_oe(cirt_link_if_i.t_sda_oe));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; answer taken where pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h0C, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 12000);
    if (k >= 12000) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic t_reset();
    chk("option", 32'hE70E, 32'(charge_option));
    chk("current", 32'h0, 32'(charge_current_code));
    chk("voltage", 32'h41A, 32'(charge_voltage_code));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
  endtask
  task automatic t_write_burst();
    apb(1'b1, 8'h04, 32'hFF);
    apb(1'b1, 8'h04, 32'hFF);
    apb(1'b1, 8'h00, 32'h8000_0202);
    chk("go err", 32'h0, 32'(er));
    apb(1'b1, 8'h00, 32'h8000_0202);
    chk("busy go err", 32'h1, 32'(er));
    wait_idle();
    chk("nack seen", 32'h0, 32'(rd[1]));
    chk("current", 32'h7F, 32'(charge_current_code));
    chk("voltage", 32'h41A, 32'(charge_voltage_code));
    chk("option", 32'hE70E, 32'(charge_option));
  endtask
  task automatic t_read_burst();
    apb(1'b1, 8'h00, 32'h8001_0203);
    wait_idle();
    apb(1'b0, 8'h08, 32'h0);
    chk("rx reg3", 32'h11F, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("rx reg4", 32'h1D0, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("rx empty", 32'h0, 32'(rd[8]));
  endtask
  task automatic t_bad_index();
    apb(1'b1, 8'h00, 32'h8000_0006);
    wait_idle();
    chk("nack seen", 32'h1, 32'(rd[1]));
    apb(1'b1, 8'h00, 32'h8001_0100);
    wait_idle();
    apb(1'b0, 8'h08, 32'h0);
    chk("rx reg0", 32'h10E, rd);
    chk("current", 32'h7F, 32'(charge_current_code));
  endtask
  // second reset with a four-cell strap
  task automatic t_cells();
    @(posedge pclk);
    presetn <= 1'b0;
    cell_count <= 2'h3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("voltage 4s", 32'h834, 32'(charge_voltage_code));
    chk("current cleared", 32'h0, 32'(charge_current_code));
    chk("option reset", 32'hE70E, 32'(charge_option));
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    t_reset();
    t_write_burst();
    t_read_burst();
    t_bad_index();
    t_cells();
    end_sim();
  end
endmodule
`default_nettype wire
